// File: core/rbg_pkg.sv
// Purpose: constants and types for the repeating bitstream generator
// Assumes: 40 MHz system clock
// Notes:   pattern words are 8 bits, one per sequencer state
package rbg_pkg;
  localparam int          NumStates  = 8;
  localparam int          WordBits   = 8;
  localparam int          MaxBits    = 64;
  localparam int          LenW       = 7;
  localparam logic [6:0]  LenReset   = 7'h40;
  localparam logic [2:0]  SelFirst   = 3'h7;
  localparam logic [2:0]  StateFirst = 3'h0;
  localparam int          StepDiv    = 4;
  localparam logic [3:0]  StepLast   = 4'h3;
  localparam logic [7:0]  WordEven   = 8'hAA;
  localparam logic [7:0]  WordOdd    = 8'h55;

  typedef enum logic [2:0] {
    SEQ_RESET = 3'b001,
    SEQ_RUN   = 3'b010,
    SEQ_IDLE  = 3'b100
  } rbg_seq_t;

  typedef struct packed {
    logic       we;
    logic [2:0] addr;
    logic [7:0] data;
  } rbg_mem_wr_t;

  typedef struct packed {
    logic       we;
    logic [6:0] len;
  } rbg_len_wr_t;
endpackage

// File: core/rbg_bitstream.sv
// Purpose: repeating serial pattern source with clock line
// Assumes: start and enable are asynchronous pins; config writes are on clk
// Notes:   the sequencer steps once per word, bits leave msb first
`timescale 1ns/100ps
module rbg_bitstream
  import rbg_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // pins
  input  wire logic        startIn,
  input  wire logic        enableIn,
  // configuration writes
  input  wire rbg_mem_wr_t memWr,
  input  wire rbg_len_wr_t lenWr,
  // serial link
  output logic             serClk,
  output logic             serData
);
  logic [1:0] startSync_q, enSync_q;
  logic       startS, enS;
  logic [7:0] mem_q [NumStates], mem_d [NumStates];
  logic [6:0] len_q, len_d;
  logic [3:0] div_q, div_d;
  logic       stepEn;
  rbg_seq_t   seq_q, seq_d;
  logic [2:0] state_q, state_d, sel_q, sel_d;
  logic [6:0] cnt_q, cnt_d;
  logic       phase_q, phase_d, clk_q, clk_d, data_q, data_d;
  logic [3:0] muxA;
  logic [1:0] muxB;
  logic       muxOut;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      startSync_q <= 2'h0;
      enSync_q    <= 2'h0;
    end else begin
      startSync_q <= {startSync_q[0], startIn};
      enSync_q    <= {enSync_q[0], enableIn};
    end
  end
  assign startS = startSync_q[1];
  assign enS    = enSync_q[1];

  // word memory and length preset
  always_comb begin
    for (int i = 0; i < NumStates; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (memWr.we) begin
      mem_d[memWr.addr] = memWr.data;
    end
    len_d = len_q;
    if (lenWr.we && lenWr.len != 7'h00 && lenWr.len <= LenReset) begin
      len_d = lenWr.len;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NumStates; i++) begin
        mem_q[i] <= (i % 2 == 0) ? WordEven : WordOdd;
      end
      len_q <= LenReset;
    end else begin
      mem_q <= mem_d;
      len_q <= len_d;
    end
  end

  // step clock divider: one phase spans StepDiv system cycles
  always_comb begin
    stepEn = (div_q == StepLast);
    div_d  = stepEn ? 4'h0 : div_q + 4'h1;
  end

  // mux: three cascaded 2-to-1 stages
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gFirst
      assign muxA[g] = sel_q[0] ? mem_q[state_q][2*g+1] : mem_q[state_q][2*g];
    end
    for (g = 0; g < 2; g++) begin : gSecond
      assign muxB[g] = sel_q[1] ? muxA[2*g+1] : muxA[2*g];
    end
  endgenerate
  assign muxOut = sel_q[2] ? muxB[1] : muxB[0];

  // sequencer and generator
  always_comb begin
    seq_d   = seq_q;
    state_d = state_q;
    sel_d   = sel_q;
    cnt_d   = cnt_q;
    phase_d = phase_q;
    clk_d   = 1'b0;
    data_d  = mem_q[state_q][7];
    case (seq_q)
      SEQ_RESET: begin
        if (startS) begin
          seq_d   = SEQ_RUN;
          state_d = 3'h1;
          sel_d   = SelFirst;
          cnt_d   = len_q;
          phase_d = 1'b0;
        end
      end
      SEQ_RUN: begin
        if (enS) begin
          data_d = muxOut;
          clk_d  = phase_q;
          if (stepEn) begin
            phase_d = ~phase_q;
            if (phase_q) begin
              if (cnt_q == 7'h01) begin
                cnt_d   = len_q;
                sel_d   = SelFirst;
                state_d = StateFirst;
              end else begin
                cnt_d = cnt_q - 7'h01;
                sel_d = sel_q - 3'h1;
                if (sel_q == 3'h0) begin
                  state_d = state_q + 3'h1;
                end
              end
            end
          end
        end
      end
      default: begin
        seq_d = SEQ_RESET;
      end
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_q   <= 4'h0;
      seq_q   <= SEQ_RESET;
      state_q <= StateFirst;
      sel_q   <= SelFirst;
      cnt_q   <= LenReset;
      phase_q <= 1'b0;
      clk_q   <= 1'b0;
      data_q  <= 1'b0;
    end else begin
      div_q   <= div_d;
      seq_q   <= seq_d;
      state_q <= state_d;
      sel_q   <= sel_d;
      cnt_q   <= cnt_d;
      phase_q <= phase_d;
      clk_q   <= clk_d;
      data_q  <= data_d;
    end
  end
  assign serClk  = clk_q;
  assign serData = data_q;

  property p_clk_off;
    @(posedge clk) disable iff (!rstn) !enS |=> !serClk;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock toggled while disabled");
  property p_msb_off;
    @(posedge clk) disable iff (!rstn) !enS |=> serData == $past(mem_q[state_q][7]);
  endproperty
  a_msb_off: assert property (p_msb_off) else $error("data not msb while disabled");
  property p_start;
    @(posedge clk) disable iff (!rstn) seq_q == SEQ_RESET && !startS |=> seq_q == SEQ_RESET;
  endproperty
  a_start: assert property (p_start) else $error("left reset without start");
  property p_ring;
    @(posedge clk) disable iff (!rstn)
      state_q != $past(state_q) && seq_q == $past(seq_q)
      |-> state_q == $past(state_q) + 3'h1 || state_q == StateFirst;
  endproperty
  a_ring: assert property (p_ring) else $error("state skipped");
  property p_onestep;
    @(posedge clk) disable iff (!rstn) !stepEn |=> sel_q == $past(sel_q);
  endproperty
  a_onestep: assert property (p_onestep) else $error("step outside phase edge");
  property p_phase;
    @(posedge clk) disable iff (!rstn) stepEn |=> !stepEn [*3];
  endproperty
  a_phase: assert property (p_phase) else $error("phase too short");
  property p_sel;
    @(posedge clk) disable iff (!rstn)
      seq_q == SEQ_RUN && sel_q != $past(sel_q) && $past(cnt_q) != 7'h01
      |-> sel_q == $past(sel_q) - 3'h1;
  endproperty
  a_sel: assert property (p_sel) else $error("select order wrong");
  property p_sel_msb;
    @(posedge clk) disable iff (!rstn)
      seq_q == SEQ_RUN && state_q != $past(state_q) |-> sel_q == SelFirst;
  endproperty
  a_sel_msb: assert property (p_sel_msb) else $error("word not started at msb");
  property p_len;
    @(posedge clk) disable iff (!rstn) cnt_q != 7'h00 && cnt_q <= LenReset;
  endproperty
  a_len: assert property (p_len) else $error("length out of range");
  c_start: cover property (@(posedge clk) disable iff (!rstn)
    seq_q == SEQ_RESET ##1 seq_q == SEQ_RUN);
  c_wrap: cover property (@(posedge clk) disable iff (!rstn)
    state_q == 3'h7 ##[1:64] state_q == 3'h0);
  c_restart: cover property (@(posedge clk) disable iff (!rstn)
    cnt_q == 7'h01 && stepEn && phase_q);
  c_halt: cover property (@(posedge clk) disable iff (!rstn)
    seq_q == SEQ_RUN && !enS);
endmodule

// File: sim/rbg_receiver.sv
// Purpose: far-side receiver that samples the serial data line
// Assumes: data is taken on each rising edge of serClk
// Notes:   newest bit lands in bits[0]
`timescale 1ns/100ps
module rbg_receiver (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // serial link
  input  wire logic         serClk,
  input  wire logic         serData,
  // captured stream
  output logic [127:0]      bits,
  output int unsigned       count
);
  logic clkSeen;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clkSeen <= 1'b0;
      bits    <= '0;
      count   <= 0;
    end else begin
      clkSeen <= serClk;
      if (serClk && !clkSeen) begin
        bits  <= {bits[126:0], serData};
        count <= count + 1;
      end
    end
  end
endmodule

// File: sim/testbench.sv
// Purpose: self-checking bench for the bitstream generator
// Assumes: reset words even 0xAA, odd 0x55, length 64 after reset
// Notes:   enable drop halts the sequencer and parks the clock line
`timescale 1ns/100ps
module testbench;
  import rbg_pkg::*;
  logic        clk = 0, rstn = 0, startIn = 0, enableIn = 0, serClk, serData, lastData;
  rbg_mem_wr_t memWr = '0;
  rbg_len_wr_t lenWr = '0;
  logic [127:0] rxBits;
  int unsigned  rxCount;
  int           failCount = 0, checksDone = 0, cycles = 0;
  always #12.5 clk = ~clk;
  rbg_bitstream rbg_bitstream_i (.clk(clk), .rstn(rstn), .startIn(startIn),
    .enableIn(enableIn), .memWr(memWr), .lenWr(lenWr), .serClk(serClk), .serData(serData));
  rbg_receiver rbg_receiver_i (.clk(clk), .rstn(rstn), .serClk(serClk),
    .serData(serData), .bits(rxBits), .count(rxCount));
  task automatic check(input logic ok, input string msg);
    checksDone++;
    if (ok !== 1'b1) begin
      failCount++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task automatic end_sim;
    if (failCount == 0 && checksDone > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failCount++;
      end_sim;
    end
  end
  task automatic wr_word(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) memWr <= {1'b1, a, d};
    @(posedge clk) memWr <= '0;
  endtask
  task automatic wr_len(input logic [6:0] l);
    @(posedge clk) lenWr <= {1'b1, l};
    @(posedge clk) lenWr <= '0;
  endtask
  // idle before start: clock parked, data shows msb of word 0
  task automatic test_idle;
    repeat (16) begin
      @(negedge clk);
      check(serClk === 1'b0 && serData === 1'b1, "idle line");
    end
  endtask
  // custom words and a 16-bit length; 65 and 0 must be ignored
  task automatic test_stream;
    wr_word(3'h1, 8'hC3);
    wr_word(3'h2, 8'h3C);
    wr_len(7'h10);
    wr_len(7'h41);
    wr_len(7'h00);
    @(posedge clk) begin
      startIn  <= 1'b1;
      enableIn <= 1'b1;
    end
    for (int i = 0; i < 2000 && rxCount < 80; i++) begin
      @(posedge clk);
      #1;
    end
    check(rxCount == 80, "stream stalled");
    check(rxBits[79:64] === 16'hC33C, "first words");
    check(rxBits[15:0] === 16'hAAC3, "restart pattern");
  endtask
  // enable low: clock held low, data constant, no bits received
  task automatic test_disable;
    int unsigned n;
    @(posedge clk) enableIn <= 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    n = rxCount;
    lastData = serData;
    repeat (16) begin
      @(negedge clk);
      check(serClk === 1'b0 && serData === lastData, "disabled");
    end
    check(rxCount == n, "bits while disabled");
    // halted on word 0 or 1: give both a low msb
    wr_word(3'h0, 8'h2A);
    wr_word(3'h1, 8'h43);
    repeat (2) @(negedge clk);
    check(serData === 1'b0, "msb not following word");
  endtask
  // mid-run reset: lines drop, defaults return, start still high restarts at word 1
  task automatic test_reset;
    @(posedge clk) rstn <= 1'b0;
    @(negedge clk) check(serClk === 1'b0 && serData === 1'b0 && rxCount == 0, "mid-run reset");
    @(posedge clk) rstn <= 1'b1;
    @(posedge clk) enableIn <= 1'b1;
    for (int i = 0; i < 1000 && rxCount < 16; i++) @(negedge clk);
    check(rxCount == 16, "no restart after reset");
    check(rxBits[15:0] === 16'h55AA, "default words");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    check(serClk === 1'b0 && serData === 1'b0, "reset levels");
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    test_idle;
    test_stream;
    test_disable;
    test_reset;
    end_sim;
  end
endmodule
